//--- logic/pcl_pkg.sv
package pcl_pkg;
  // ****************************************************************
  // clocking and switching timing
  // ****************************************************************
  localparam int CLK_HZ = 250_000_000;
  localparam int CLK_MHZ = 250;
  localparam int FSW_HZ = 75_000;
  localparam int PERIOD_CYC_I = CLK_HZ / FSW_HZ;
  localparam int DEAD_NS = 100;
  localparam int DEAD_CYC_I = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int VIN_TRIG_NS = 300;
  localparam int VIN_TRIG_CYC_I = (VIN_TRIG_NS * CLK_MHZ + 999) / 1000;
  localparam logic [11:0] PERIOD_CYC = 12'(PERIOD_CYC_I);
  localparam logic [11:0] HALF_CYC = 12'(PERIOD_CYC_I / 2);
  localparam logic [11:0] DEAD_CYC = 12'(DEAD_CYC_I);
  localparam logic [11:0] VIN_TRIG_CYC = 12'(VIN_TRIG_CYC_I);
  // ****************************************************************
  // data scaling
  // ****************************************************************
  localparam int ADC_W = 12;
  localparam int DAC_W = 12;
  localparam logic [11:0] DAC_MAX = 12'hfff;
  localparam logic [12:0] COEF_ONE = 13'h1000;
  localparam int COEF_SHIFT = 12;
  localparam int ADC_REF_MV = 3300;
  localparam logic [16:0] IBASE_SEC_CA = 17'h0256c;
  localparam int IBASE_PRI_MA = 3830;
  localparam int KP_SHIFT = 6;
  localparam int INTEG_SHIFT = 4;
  localparam logic signed [17:0] INTEG_MAX = 18'sh0fff0;
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [11:0] CNT_RST = 12'h000;
  localparam logic [11:0] DAC_RST = 12'h000;
endpackage : pcl_pkg

//--- logic/pcl_slope.sv
`timescale 1ns/1ps
module pcl_slope
  import pcl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic [12:0] a_coef,
  input wire logic [11:0] valley,
  input wire logic [11:0] ic,
  input wire logic [12:0] vin_reb,
  input wire logic [11:0] vout,
  output logic [11:0] result,
  output logic valid
);
  typedef struct packed {
    logic [11:0] result;
    logic valid;
  } pcl_slope_state_type;

  pcl_slope_state_type st_r, st_nxt;
  logic [12:0] a_eff;
  logic [12:0] b_eff;
  logic [25:0] mix;
  logic [13:0] scaled;

  always_comb begin
    // no power transfer possible when reflected input is at or below output: plain reference
    a_eff = (vin_reb > {1'b0, vout}) ? ((a_coef > COEF_ONE) ? COEF_ONE : a_coef) : 13'h0000;
    b_eff = COEF_ONE - a_eff; // RULE_13
    mix = 26'(a_eff * valley) + 26'(b_eff * ic); // RULE_13
    scaled = mix[25:COEF_SHIFT];
    st_nxt = st_r;
    st_nxt.valid = start; // RULE_04
    if (start) begin
      st_nxt.result = (scaled > {2'b00, DAC_MAX}) ? DAC_MAX : scaled[11:0]; // RULE_14
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign result = st_r.result;
  assign valid = st_r.valid;

  property p_plain_ref;
    @(posedge mclk) disable iff (rst) start && vin_reb <= {1'b0, vout} |=> result == $past(ic);
  endproperty
  a_plain_ref: assert property (p_plain_ref) else $error("reference not passed through"); // RULE_13

  property p_done;
    @(posedge mclk) disable iff (rst) start |=> valid ##1 !valid || start;
  endproperty
  a_done: assert property (p_done) else $error("slope result not valid after start"); // RULE_04
endmodule : pcl_slope

//--- logic/pcl_loop.sv
// Function
// RULE_01: error is reference minus output sample; compensator yields uncompensated reference.
// RULE_02: trigger current conversion at start of each half period (valley).
// RULE_03: input voltage trigger only inside a power-delivery interval.
// RULE_04: compute slope-compensated reference at start of every half cycle.
// RULE_05: scale compensated reference and load it into 12-bit DAC.
// RULE_06: comparator high means sensed current reached programmed peak.
// RULE_07: comparator high ends active high-side drive for rest of half cycle.
// RULE_08: bridge switches at 75 kHz; update runs at twice that rate.
// RULE_09: current codes are against 3.3 V; full scale is 3.83 A / 95.8 A.
// RULE_10: legs complementary with dead time; second leg fixed 180 degrees behind.
// RULE_11: rectifier high and low run half periods, 180 degrees apart.
// RULE_12: input voltage sample shifted left one bit before use.
// RULE_13: compensated reference is A times valley plus (1-A) times reference.
// RULE_14: saturate DAC code to its unsigned range.
// RULE_15: new DAC threshold takes effect only at a half-cycle boundary.
`timescale 1ns/1ps
module pcl_loop
  import pcl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [11:0] vout_ref,
  input wire logic [7:0] kp,
  input wire logic [7:0] ki,
  input wire logic [12:0] a_coef,
  input wire logic [11:0] current_sense_channel,
  input wire logic current_valid,
  input wire logic [11:0] vout_sense_channel,
  input wire logic vout_valid,
  input wire logic [11:0] vin_sense_channel,
  input wire logic vin_valid,
  input wire logic cmp_in,
  output logic current_trig,
  output logic vout_trig,
  output logic vin_trig,
  output logic [11:0] dac_code,
  output logic dac_load,
  output logic leg_a_high_drive,
  output logic leg_a_low_drive,
  output logic leg_b_high_drive,
  output logic leg_b_low_drive,
  output logic rectifier_high_drive,
  output logic rectifier_low_drive,
  output logic [16:0] valley_sec_ca
);
  import pcl_pkg::*;

  typedef struct packed {
    logic [11:0] cnt;
    logic [2:0] cmp_s;
    logic cmp_f;
    logic fault;
    logic [11:0] fcnt;
    logic hi_a;
    logic lo_a;
    logic hi_b;
    logic lo_b;
    logic rh;
    logic rl;
    logic trig_i;
    logic trig_vo;
    logic trig_vi;
    logic [11:0] valley;
    logic [11:0] vin;
    logic [11:0] vout;
    logic signed [12:0] err;
    logic signed [17:0] integ;
    logic [11:0] ic;
    logic [11:0] dac;
    logic [11:0] pend;
    logic load;
    logic [16:0] valley_ca;
    logic [11:0] run_a;
    logic [11:0] res_chk;
  } pcl_loop_state_type;

  pcl_loop_state_type st_r, st_nxt;
  logic sec;
  logic [11:0] hcnt;
  logic half_start;
  logic fault_eff;
  logic slope_valid;
  logic [11:0] slope_out;
  logic signed [17:0] integ_sum;
  logic signed [21:0] prop;
  logic signed [17:0] ic_sum;
  logic [28:0] ca_prod;

  // ****************************************************************
  // slope compensation
  // ****************************************************************
  pcl_slope u_slope (
    .mclk(mclk),
    .rst(rst),
    .start(half_start),
    .a_coef(a_coef),
    .valley(st_r.valley),
    .ic(st_r.ic),
    .vin_reb({st_r.vin, 1'b0}), // RULE_12
    .vout(st_r.vout),
    .result(slope_out),
    .valid(slope_valid)
  );

  // ****************************************************************
  // timing, drives, sampling and loop
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    sec = st_r.cnt >= HALF_CYC;
    hcnt = sec ? st_r.cnt - HALF_CYC : st_r.cnt;
    half_start = hcnt == 12'h000; // RULE_08
    // period counter; 3333 cycles at 250 MHz gives the 75 kHz bridge rate
    st_nxt.cnt = (st_r.cnt == PERIOD_CYC - 12'h001) ? CNT_RST : st_r.cnt + 12'h001; // RULE_08
    // comparator pin: three stages, level accepted once stages two and three agree
    st_nxt.cmp_s = {st_r.cmp_s[1:0], cmp_in};
    if (st_r.cmp_s[1] == st_r.cmp_s[2]) begin
      st_nxt.cmp_f = st_r.cmp_s[2];
    end
    // high comparator output means peak reached during this power interval
    fault_eff = st_r.fault && !half_start;
    st_nxt.fault = (st_r.cmp_f && (st_r.hi_a || st_r.hi_b)) || fault_eff; // RULE_06 RULE_07
    st_nxt.fcnt = !fault_eff ? 12'h000 : (st_r.fcnt < DEAD_CYC ? st_r.fcnt + 12'h001 : st_r.fcnt);
    // leg a delivers in the first half, leg b in the second: fixed 180 degree offset
    st_nxt.hi_a = !sec && hcnt >= DEAD_CYC && !st_nxt.fault; // RULE_07 RULE_10
    st_nxt.hi_b = sec && hcnt >= DEAD_CYC && !st_nxt.fault; // RULE_07 RULE_10
    st_nxt.lo_a = sec ? (st_r.lo_a || hcnt >= DEAD_CYC) && st_r.cnt != PERIOD_CYC - 12'h001
                      : fault_eff && st_r.fcnt >= DEAD_CYC; // RULE_10
    st_nxt.lo_b = !sec ? (st_r.lo_b || hcnt >= DEAD_CYC) && st_r.cnt != HALF_CYC - 12'h001
                       : fault_eff && st_r.fcnt >= DEAD_CYC; // RULE_10
    st_nxt.rh = !sec && hcnt >= DEAD_CYC; // RULE_11
    st_nxt.rl = sec && hcnt >= DEAD_CYC; // RULE_11
    // conversions
    st_nxt.trig_i = half_start; // RULE_02
    st_nxt.trig_vo = half_start;
    // skipped when the peak already ended delivery: primary is freewheeling then
    st_nxt.trig_vi = hcnt == VIN_TRIG_CYC && st_nxt.hi_a | st_nxt.hi_b; // RULE_03
    if (current_valid) begin
      st_nxt.valley = current_sense_channel;
    end
    if (vin_valid) begin
      st_nxt.vin = vin_sense_channel;
    end
    ca_prod = 29'(st_r.valley * IBASE_SEC_CA);
    st_nxt.valley_ca = ca_prod[28:12]; // RULE_09
    // voltage loop: proportional plus integral, output clamped to the current range
    integ_sum = st_r.integ + 18'(($signed({1'b0, ki}) * st_r.err) >>> INTEG_SHIFT);
    prop = $signed({1'b0, kp}) * st_r.err;
    ic_sum = (st_r.integ >>> INTEG_SHIFT) + 18'(prop >>> KP_SHIFT);
    if (vout_valid) begin
      st_nxt.vout = vout_sense_channel;
      st_nxt.err = $signed({1'b0, vout_ref}) - $signed({1'b0, vout_sense_channel}); // RULE_01
      st_nxt.integ = integ_sum < 0 ? 18'sh0 : (integ_sum > INTEG_MAX ? INTEG_MAX : integ_sum);
      st_nxt.ic = ic_sum < 0 ? 12'h000 : (ic_sum > 18'sh00fff ? DAC_MAX : ic_sum[11:0]); // RULE_01
    end
    // new threshold waits for the next boundary so it never moves mid-pulse
    if (slope_valid) begin
      st_nxt.pend = slope_out; // RULE_05
    end
    st_nxt.load = half_start; // RULE_15
    if (half_start) begin
      st_nxt.dac = st_r.pend; // RULE_15
    end
    // check helpers: a half is too long for a repetition, so count the high run instead
    st_nxt.run_a = st_r.hi_a ? st_r.run_a + 12'h001 : 12'h000;
    if (slope_valid) begin
      st_nxt.res_chk = slope_out;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign current_trig = st_r.trig_i;
  assign vout_trig = st_r.trig_vo;
  assign vin_trig = st_r.trig_vi;
  assign dac_code = st_r.dac;
  assign dac_load = st_r.load;
  assign leg_a_high_drive = st_r.hi_a;
  assign leg_a_low_drive = st_r.lo_a;
  assign leg_b_high_drive = st_r.hi_b;
  assign leg_b_low_drive = st_r.lo_b;
  assign rectifier_high_drive = st_r.rh;
  assign rectifier_low_drive = st_r.rl;
  assign valley_sec_ca = st_r.valley_ca;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_trig_i;
    @(posedge mclk) disable iff (rst) st_r.cnt == HALF_CYC |=> current_trig ##1 !current_trig;
  endproperty
  a_trig_i: assert property (p_trig_i) else $error("current trigger missing"); // RULE_02

  property p_vin_pos;
    @(posedge mclk) disable iff (rst) vin_trig |-> leg_a_high_drive || leg_b_high_drive;
  endproperty
  a_vin_pos: assert property (p_vin_pos) else $error("input trigger outside delivery"); // RULE_03

  property p_err;
    @(posedge mclk) disable iff (rst)
      vout_valid |=> st_r.err == $signed({1'b0, $past(vout_ref)})
        - $signed({1'b0, $past(vout_sense_channel)});
  endproperty
  a_err: assert property (p_err) else $error("voltage error wrong"); // RULE_01

  property p_dac_edge;
    @(posedge mclk) disable iff (rst) $changed(dac_code) |-> dac_load;
  endproperty
  a_dac_edge: assert property (p_dac_edge) else $error("threshold moved mid-half"); // RULE_15

  property p_dac_val;
    @(posedge mclk) disable iff (rst) dac_load |-> dac_code == st_r.res_chk;
  endproperty
  a_dac_val: assert property (p_dac_val) else $error("dac not loaded with result"); // RULE_05

  property p_cut;
    @(posedge mclk) disable iff (rst) st_r.cmp_f && leg_a_high_drive |=> !leg_a_high_drive [*3];
  endproperty
  a_cut: assert property (p_cut) else $error("high drive not ended by comparator"); // RULE_07

  property p_dead_a;
    @(posedge mclk) disable iff (rst) $fell(leg_a_high_drive) |-> !leg_a_low_drive [*8];
  endproperty
  a_dead_a: assert property (p_dead_a) else $error("leg a dead time violated"); // RULE_10

  property p_phase;
    @(posedge mclk) disable iff (rst) st_r.run_a <= HALF_CYC - DEAD_CYC;
  endproperty
  a_phase: assert property (p_phase) else $error("leg a active past its half"); // RULE_08

  property p_rect;
    @(posedge mclk) disable iff (rst)
      !(rectifier_high_drive && rectifier_low_drive) && !(leg_b_high_drive && leg_b_low_drive);
  endproperty
  a_rect: assert property (p_rect) else $error("overlapping drives"); // RULE_11

  property p_fault_rank;
    @(posedge mclk) disable iff (rst) st_r.cmp_s[2] && st_r.cmp_s[1] |=> st_r.cmp_f;
  endproperty
  a_fault_rank: assert property (p_fault_rank) else $error("comparator level missed"); // RULE_06
endmodule : pcl_loop

//--- tb/pcl_stage_model.sv
`timescale 1ns/1ps
module pcl_stage_model
  import pcl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] trig,
  input wire logic hi_on,
  input wire logic [11:0] dac_code,
  input wire logic slow,
  input wire logic [3:0] slope,
  input wire logic [35:0] vals,
  output logic [35:0] dat,
  output logic [2:0] vld,
  output logic cmp_in = 1'b0
);
  int cd[3];
  int cur;
  logic [35:0] hold = '0;
  // ********
  // converters: data lines show garbage outside the valid pulse
  // ********
  for (genvar i = 0; i < 3; i++) begin : g_ch
    assign dat[12*i+:12] = vld[i] ? hold[12*i+:12] : ~hold[12*i+:12];
  end
  always @(posedge mclk) begin
    for (int i = 0; i < 3; i++) begin
      vld[i] <= !rst && !trig[i] && cd[i] == 1;
      if (rst) begin
        cd[i] <= 0;
      end else if (trig[i]) begin
        cd[i] <= slow ? 40 : 3;
      end else if (cd[i] > 0) begin
        cd[i] <= cd[i] - 1;
        if (cd[i] == 1) begin
          hold[12*i+:12] <= vals[12*i+:12];
        end
      end
    end
  end
  // ********
  // sensed current ramps while a high side conducts; slope 0 never trips
  // ********
  always @(posedge mclk) begin
    cur <= (hi_on && !rst) ? cur + int'(slope) : 0;
    cmp_in <= hi_on && (cur > int'(dac_code));
  end
endmodule : pcl_stage_model

//--- tb/test_peak_current_loop_control.sv
`timescale 1ns/1ps
module test_peak_current_loop_control;
  import pcl_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] vout_ref = '0;
  logic [7:0] kp = '0;
  logic [7:0] ki = '0;
  logic [12:0] a_coef = '0;
  logic slow = 1'b0;
  logic [3:0] slope = '0;
  logic [35:0] vals = '0;
  logic [35:0] dat;
  logic [2:0] vld;
  logic cmp_in, current_trig, vout_trig, vin_trig, dac_load;
  logic a_h, a_l, b_h, b_l, r_h, r_l;
  logic [11:0] dac_code;
  logic [11:0] last_code = '0;
  logic [11:0] v;
  logic [16:0] valley_sec_ca;
  logic [3:0] prv = '0;
  logic [3:0] hv;
  int failures = 0;
  int compares = 0;
  int hc = 0;
  int half_b = 1;
  int streak = 0;
  int started = 0;
  int err_m = 0;
  int integ_m = 0;
  int ic_m = 0;
  int valley_m = 0;
  int vout_m = 0;
  int vin_m = 0;
  int want = 0;
  assign hv = {r_l, r_h, b_h, a_h};
  always #2 mclk = ~mclk;
  pcl_loop dut (.mclk(mclk), .rst(rst), .vout_ref(vout_ref), .kp(kp), .ki(ki),
    .a_coef(a_coef), .current_sense_channel(dat[11:0]), .current_valid(vld[0]),
    .vout_sense_channel(dat[23:12]), .vout_valid(vld[1]),
    .vin_sense_channel(dat[35:24]), .vin_valid(vld[2]), .cmp_in(cmp_in),
    .current_trig(current_trig), .vout_trig(vout_trig), .vin_trig(vin_trig),
    .dac_code(dac_code), .dac_load(dac_load), .leg_a_high_drive(a_h),
    .leg_a_low_drive(a_l), .leg_b_high_drive(b_h), .leg_b_low_drive(b_l),
    .rectifier_high_drive(r_h), .rectifier_low_drive(r_l),
    .valley_sec_ca(valley_sec_ca));
  pcl_stage_model stage (.mclk(mclk), .rst(rst), .trig({vin_trig, vout_trig, current_trig}),
    .hi_on(a_h | b_h), .dac_code(dac_code), .slow(slow), .slope(slope), .vals(vals),
    .dat(dat), .vld(vld), .cmp_in(cmp_in));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task wrap_up;
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  function automatic int slope_code();
    int a;
    int r;
    a = (a_coef > 13'h1000) ? 4096 : int'(a_coef);
    if (vin_m * 2 <= vout_m) a = 0;
    r = (a * valley_m + (4096 - a) * ic_m) >>> 12;
    return (r > 4095) ? 4095 : r;
  endfunction : slope_code
  // ********
  // monitor and reference model, sampled mid-cycle
  // ********
  always @(negedge mclk) begin
    if (!rst) begin
      check("vout_trig", vout_trig, current_trig);
      check("dac_load", dac_load, current_trig);
      check("overlap", {a_h & a_l, b_h & b_l, r_h & r_l}, 3'b000);
      if (!dac_load) check("dac_hold", dac_code, last_code);
      hc++;
      if (current_trig) begin
        if (started) check("half_len", hc - 1, half_b ? 1667 : 1666);
        started = 1;
        half_b = 1 - half_b;
        hc = 1;
        check("dac_code", dac_code, want);
        check("valley_sec", valley_sec_ca, (valley_m * int'(IBASE_SEC_CA)) / 4096);
        want = slope_code();
      end
      if (vin_trig) begin
        check("vin_at", hc, 76);
        check("vin_power", a_h | b_h, 1'b1);
      end
      for (int i = 0; i < 4; i++) begin
        if (hv[i] && !prv[i]) check("rise_at", hc * 2 + half_b, 52 + (i & 1));
      end
      streak = (cmp_in && (a_h || b_h)) ? streak + 1 : 0;
      check("fault_stop", streak > 6, 1'b0);
      if (vld[0]) valley_m = int'(dat[11:0]);
      if (vld[2]) vin_m = int'(dat[35:24]);
      if (vld[1]) begin
        // one-sample delay: gains act on the previous error
        ic_m = (integ_m >>> 4) + ((int'(kp) * err_m) >>> 6);
        ic_m = (ic_m < 0) ? 0 : (ic_m > 4095) ? 4095 : ic_m;
        integ_m = integ_m + ((int'(ki) * err_m) >>> 4);
        integ_m = (integ_m < 0) ? 0 : (integ_m > 65520) ? 65520 : integ_m;
        err_m = int'(vout_ref) - int'(dat[23:12]);
        vout_m = int'(dat[23:12]);
      end
      last_code = dac_code;
      prv = hv;
    end
  end
  // ********
  // stimulus: new settings each half, just after the threshold load
  // ********
  task wait_load;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (dac_load !== 1'b1 && n < 2000);
    if (n >= 2000) failures++;
  endtask : wait_load
  initial begin
    void'($urandom(32'h3af98ed6));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      wait_load();
      a_coef <= 13'($urandom_range(0, 4200));
      kp <= (i < 12) ? 8'h00 : 8'($urandom);
      ki <= (i < 12) ? 8'h00 : 8'($urandom_range(0, 3));
      vout_ref <= 12'($urandom);
      slope <= 4'($urandom_range(0, 8));
      slow <= i[0];
      v = 12'($urandom) & 12'hffe;
      // every fifth half puts the doubled input exactly on the output sample
      vals <= {(i % 5 == 0) ? {1'b0, v[11:1]} : 12'($urandom), v, 12'($urandom)};
    end
    wrap_up();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    wrap_up();
  end
endmodule : test_peak_current_loop_control
